// File: verilog/gprs_sched.sv
// Packet command interpreter and periodic report scheduler
`timescale 1ns/100ps
module gprs_sched #(
  parameter int unsigned EPOCH_CYCLES = gprs_pkg::EPOCH_CYC
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  output      logic [7:0]  tx_data,
  output      logic        tx_valid,
  input  wire logic        tx_ready,
  input  wire logic [7:0]  pl_data,
  input  wire logic        pl_last,
  input  wire logic        pl_valid,
  output      logic        pl_ready,
  output      logic [7:0]  report_id,
  output      logic [7:0]  report_sub,
  input  wire logic        fix_valid,
  input  wire logic        diff_active,
  input  wire logic [31:0] nv_rd_word,
  output      logic [31:0] nv_wr_word,
  output      logic        nv_wr,
  output      logic        cmd_ready,
  output      logic        irq
);
  localparam logic [7:0] DLE = gprs_pkg::DLE;
  localparam logic [7:0] ETX = gprs_pkg::ETX;

  // Byte-enable mask
  function automatic logic [31:0] bmask(input logic [3:0] s);
    bmask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction
  // Word address match
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a[7:2] == o[7:2]);
  endfunction
  // Slots enabled by the option bits
  function automatic logic [12:0] pv_mask(input logic [15:0] o);
    pv_mask = '0;
    pv_mask[gprs_pkg::P_PXYZ]  = o[gprs_pkg::O_XYZ];
    pv_mask[gprs_pkg::P_PLLA]  = o[gprs_pkg::O_LLA];
    pv_mask[gprs_pkg::P_PGRID] = o[gprs_pkg::O_GRID];
    pv_mask[gprs_pkg::P_PCOMB] = o[gprs_pkg::O_GRID];
    pv_mask[gprs_pkg::P_VXYZ]  = o[gprs_pkg::O_VXYZ];
    pv_mask[gprs_pkg::P_VENU]  = o[gprs_pkg::O_VENU];
  endfunction
  // Identifier and subcode of a slot
  function automatic logic [15:0] id_of(input logic [3:0] i, input logic d);
    case (i)
      gprs_pkg::P_VER:   id_of = {gprs_pkg::ID_VER, 8'h00};
      gprs_pkg::P_HLTH:  id_of = {gprs_pkg::ID_HLTH, 8'h00};
      gprs_pkg::P_STAT:  id_of = {gprs_pkg::ID_STAT, 8'h00};
      gprs_pkg::P_PXYZ:  id_of = {d ? gprs_pkg::ID_XYZ_D : gprs_pkg::ID_XYZ_S, 8'h00};
      gprs_pkg::P_PLLA:  id_of = {d ? gprs_pkg::ID_LLA_D : gprs_pkg::ID_LLA_S, 8'h00};
      gprs_pkg::P_PGRID: id_of = {gprs_pkg::ID_SUPER, d ? gprs_pkg::SUB_GR_D : gprs_pkg::SUB_GR_S};
      gprs_pkg::P_PCOMB: id_of = {gprs_pkg::ID_SUPER, gprs_pkg::SUB_COMB};
      gprs_pkg::P_VXYZ:  id_of = {gprs_pkg::ID_VXYZ, 8'h00};
      gprs_pkg::P_VENU:  id_of = {gprs_pkg::ID_VENU, 8'h00};
      gprs_pkg::P_TIME:  id_of = {gprs_pkg::ID_TIME, 8'h00};
      gprs_pkg::P_DIFF:  id_of = {gprs_pkg::ID_DIFF, 8'h00};
      gprs_pkg::P_CORR:  id_of = {gprs_pkg::ID_CORR, 8'h00};
      default:           id_of = {gprs_pkg::ID_CFG, 8'h00};
    endcase
  endfunction
  // Lowest pending slot
  function automatic logic [3:0] first(input logic [12:0] p);
    first = 4'h0;
    for (int k = gprs_pkg::NPEND - 1; k >= 0; k--) begin
      if (p[k]) first = 4'(k);
    end
  endfunction

  logic [15:0]        opt_ff, cfg_ff, cnt_ff;
  logic [12:0]        pend_ff, nxt_pend, set_v, clr_v;
  logic [3:0]         isr_ff, imr_ff, ev, cur_ff;
  logic               ready_ff, load_ff, nv_wr_ff, last_ff, tx_vld_ff;
  logic [7:0]         tx_data_ff, rid_ff, rsub_ff, nxt_byte;
  gprs_pkg::gprs_tx_e st_ff, nxt_st;
  logic               esc_ff, infr_ff;
  logic [7:0]         cid_ff, b0_ff, b1_ff;
  logic [1:0]         rn_ff;
  logic [25:0]        div_ff;
  logic [7:0]         tm_ff;
  logic [4:0]         hc_ff;
  logic               aw_ff, w_ff, bvalid_ff, rvalid_ff;
  logic [7:0]         awa_ff;
  logic [31:0]        wd_ff, rdata_ff, rd_word;
  logic [3:0]         ws_ff;
  logic [1:0]         bresp_ff, rresp_ff;

  // Output byte slot and dispatch
  wire        slot   = !tx_vld_ff || tx_ready;
  wire        any    = |pend_ff;
  wire [3:0]  sel    = first(pend_ff);
  wire [15:0] sel_id = id_of(sel, opt_ff[gprs_pkg::O_DBL]);
  wire        ld     = slot && (st_ff != gprs_pkg::TX_IDLE || any)
                       && (st_ff != gprs_pkg::TX_PL || pl_valid);
  wire        disp   = ld && st_ff == gprs_pkg::TX_IDLE;
  wire        sent   = ld && st_ff == gprs_pkg::TX_ETX;
  wire        rdy_ev = sent && cur_ff == gprs_pkg::P_DIFF && !ready_ff;

  // Byte sequence of one outgoing frame
  always_comb begin
    nxt_st   = st_ff;
    nxt_byte = DLE;
    case (st_ff)
      gprs_pkg::TX_IDLE: nxt_st = gprs_pkg::TX_ID;
      gprs_pkg::TX_ID: begin
        nxt_byte = rid_ff;
        nxt_st   = gprs_pkg::TX_PL;
      end
      gprs_pkg::TX_PL: begin
        nxt_byte = pl_data;
        if (pl_data == DLE) nxt_st = gprs_pkg::TX_STUFF;
        else if (pl_last) nxt_st = gprs_pkg::TX_EDLE;
      end
      gprs_pkg::TX_STUFF: nxt_st = last_ff ? gprs_pkg::TX_EDLE : gprs_pkg::TX_PL;
      gprs_pkg::TX_EDLE: nxt_st = gprs_pkg::TX_ETX;
      default: begin
        nxt_byte = ETX;
        nxt_st   = gprs_pkg::TX_IDLE;
      end
    endcase
  end

  // Transmit registers
  always_ff @(posedge clock) begin
    if (rst) begin
      st_ff     <= gprs_pkg::TX_IDLE;
      tx_vld_ff <= 1'b0;
    end else if (ld) begin
      st_ff     <= nxt_st;
      tx_vld_ff <= 1'b1;
    end else if (tx_ready) begin
      tx_vld_ff <= 1'b0;
    end
  end

  // Frame data and selected report
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_data_ff <= 8'h00;
      last_ff    <= 1'b0;
      cur_ff     <= 4'h0;
      rid_ff     <= 8'h00;
      rsub_ff    <= 8'h00;
    end else begin
      if (ld) tx_data_ff <= nxt_byte;
      if (ld && st_ff == gprs_pkg::TX_PL) last_ff <= pl_last;
      if (disp) cur_ff <= sel;
      if (disp) rid_ff <= sel_id[15:8];
      if (disp) rsub_ff <= sel_id[7:0];
    end
  end

  // Incoming frame parser with unstuffing
  always_ff @(posedge clock) begin
    if (rst) begin
      esc_ff  <= 1'b0;
      infr_ff <= 1'b0;
      cid_ff  <= 8'h00;
      rn_ff   <= 2'h0;
      b0_ff   <= 8'h00;
      b1_ff   <= 8'h00;
    end else if (rx_valid) begin
      esc_ff <= !esc_ff && rx_data == DLE;
      if (esc_ff && rx_data == ETX) begin
        infr_ff <= 1'b0;
      end else if (esc_ff && rx_data != DLE) begin
        infr_ff <= 1'b1;
        cid_ff  <= rx_data;
        rn_ff   <= 2'h0;
      end else if (infr_ff && (esc_ff || rx_data != DLE)) begin
        if (rn_ff == 2'h0) b0_ff <= rx_data;
        if (rn_ff == 2'h1) b1_ff <= rx_data;
        if (rn_ff != 2'h2) rn_ff <= rn_ff + 2'h1;
      end
    end
  end

  // Command decode at frame end
  wire rx_end   = rx_valid && esc_ff && rx_data == ETX && infr_ff;
  wire cmd_ok   = rx_end && ready_ff;
  wire is_time  = cmd_ok && cid_ff == gprs_pkg::C_TIME;
  wire is_corq  = cmd_ok && cid_ff == gprs_pkg::C_CORQ;
  wire is_cfg   = cmd_ok && cid_ff == gprs_pkg::C_CFG;
  wire is_opt   = cmd_ok && cid_ff == gprs_pkg::C_OPT;
  wire is_dc    = cmd_ok && (cid_ff == gprs_pkg::C_DC1 || cid_ff == gprs_pkg::C_DC2);
  wire known    = is_time || is_corq || is_cfg || is_opt || is_dc;
  wire c_set    = rn_ff == 2'h2;
  wire cmd_bad  = rx_end && !known;

  // Epoch divider and report period counters
  wire       tick   = div_ff == 26'(EPOCH_CYCLES - 1);
  wire       tk     = tick && ready_ff;
  wire [7:0] t_lim  = fix_valid ? gprs_pkg::SEC_FIX : gprs_pkg::SEC_NOFIX;
  wire       t_wrap = tk && (tm_ff + 8'h01 >= t_lim);
  wire       h_wrap = tk && hc_ff == gprs_pkg::SEC_SLOW - 5'h01;
  always_ff @(posedge clock) begin
    if (rst) begin
      div_ff <= '0;
      tm_ff  <= 8'h00;
      hc_ff  <= 5'h00;
    end else begin
      div_ff <= tick ? '0 : div_ff + 26'h1;
      if (tk) tm_ff <= t_wrap ? 8'h00 : tm_ff + 8'h01;
      if (tk) hc_ff <= h_wrap ? 5'h00 : hc_ff + 5'h01;
    end
  end

  // Pending report set and clear
  always_comb begin
    set_v = load_ff ? pv_mask(nv_rd_word[15:0]) : '0;
    if (tk) set_v = set_v | pv_mask(opt_ff);
    set_v[gprs_pkg::P_TIME] = set_v[gprs_pkg::P_TIME] || t_wrap || is_time;
    set_v[gprs_pkg::P_HLTH] = h_wrap;
    set_v[gprs_pkg::P_STAT] = h_wrap;
    set_v[gprs_pkg::P_DIFF] = h_wrap && diff_active;
    set_v[gprs_pkg::P_CORR] = is_corq;
    set_v[gprs_pkg::P_CFG]  = is_cfg;
    clr_v = '0;
    if (disp) clr_v[sel] = 1'b1;
    nxt_pend = (pend_ff & ~clr_v) | set_v;
  end

  // Bus write acceptance
  wire        awrdy = !aw_ff && !bvalid_ff;
  wire        wrdy  = !w_ff && !bvalid_ff;
  wire        we    = aw_ff && w_ff && !bvalid_ff;
  wire [31:0] wm    = bmask(ws_ff);
  wire [31:0] wv    = wd_ff & wm;
  wire        w_opt = we && hit(awa_ff, gprs_pkg::R_OPT);
  wire        w_cfg = we && hit(awa_ff, gprs_pkg::R_CFG);
  wire        w_isr = we && hit(awa_ff, gprs_pkg::R_ISR);
  wire        w_imr = we && hit(awa_ff, gprs_pkg::R_IMR);
  wire        w_map = w_opt || w_cfg || w_isr || w_imr || hit(awa_ff, gprs_pkg::R_STAT)
                      || hit(awa_ff, gprs_pkg::R_CNT);
  wire        c_opt = is_opt && c_set;
  wire        c_cfg = is_cfg && c_set;
  always_ff @(posedge clock) begin
    if (rst) begin
      aw_ff     <= 1'b0;
      w_ff      <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= gprs_pkg::RSP_OK;
    end else begin
      if (s_axi_awvalid && awrdy) aw_ff <= 1'b1;
      if (s_axi_wvalid && wrdy) w_ff <= 1'b1;
      if (we) begin
        aw_ff     <= 1'b0;
        w_ff      <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= w_map ? gprs_pkg::RSP_OK : gprs_pkg::RSP_ERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (s_axi_awvalid && awrdy) awa_ff <= s_axi_awaddr;
    if (s_axi_wvalid && wrdy) wd_ff <= s_axi_wdata;
    if (s_axi_wvalid && wrdy) ws_ff <= s_axi_wstrb;
  end

  // Option, configuration and status registers
  assign ev = {rdy_ev, sent, cmd_bad, cmd_ok && known};
  always_ff @(posedge clock) begin
    if (rst) begin
      load_ff  <= 1'b1;
      opt_ff   <= gprs_pkg::OPT_RST;
      cfg_ff   <= gprs_pkg::CFG_RST;
      pend_ff  <= gprs_pkg::PU_SET;
      ready_ff <= 1'b0;
      isr_ff   <= 4'h0;
      imr_ff   <= 4'h0;
      cnt_ff   <= 16'h0000;
      nv_wr_ff <= 1'b0;
    end else begin
      load_ff  <= 1'b0;
      pend_ff  <= nxt_pend;
      ready_ff <= ready_ff || rdy_ev;
      isr_ff   <= (isr_ff & ~(w_isr ? wv[3:0] : 4'h0)) | ev;
      nv_wr_ff <= w_opt || w_cfg || c_opt || c_cfg;
      if (is_dc) cnt_ff <= cnt_ff + 16'h0001;
      if (w_imr) imr_ff <= (imr_ff & ~wm[3:0]) | wv[3:0];
      if (load_ff) opt_ff <= nv_rd_word[15:0];
      else if (w_opt) opt_ff <= (opt_ff & ~wm[15:0]) | wv[15:0];
      else if (c_opt) opt_ff <= {b1_ff, b0_ff};
      if (load_ff) cfg_ff <= nv_rd_word[31:16];
      else if (w_cfg) cfg_ff <= (cfg_ff & ~wm[15:0]) | wv[15:0];
      else if (c_cfg) cfg_ff <= {b1_ff, b0_ff};
    end
  end

  // Read data selection
  always_comb begin
    if (hit(s_axi_araddr, gprs_pkg::R_OPT)) rd_word = {16'h0000, opt_ff};
    else if (hit(s_axi_araddr, gprs_pkg::R_CFG)) rd_word = {16'h0000, cfg_ff};
    else if (hit(s_axi_araddr, gprs_pkg::R_STAT))
      rd_word = {3'h0, pend_ff, 12'h000, tx_vld_ff, diff_active, fix_valid, ready_ff};
    else if (hit(s_axi_araddr, gprs_pkg::R_ISR)) rd_word = {28'h0, isr_ff};
    else if (hit(s_axi_araddr, gprs_pkg::R_IMR)) rd_word = {28'h0, imr_ff};
    else if (hit(s_axi_araddr, gprs_pkg::R_CNT)) rd_word = {16'h0000, cnt_ff};
    else rd_word = 32'h0;
  end
  wire r_map = s_axi_araddr[7:2] <= gprs_pkg::R_CNT[7:2];
  always_ff @(posedge clock) begin
    if (rst) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0;
      rresp_ff  <= gprs_pkg::RSP_OK;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_word;
      rresp_ff  <= r_map ? gprs_pkg::RSP_OK : gprs_pkg::RSP_ERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Port drive
  assign s_axi_awready = awrdy;
  assign s_axi_wready  = wrdy;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign tx_data       = tx_data_ff;
  assign tx_valid      = tx_vld_ff;
  assign pl_ready      = slot && st_ff == gprs_pkg::TX_PL;
  assign report_id     = rid_ff;
  assign report_sub    = rsub_ff;
  assign nv_wr         = nv_wr_ff;
  assign nv_wr_word    = {cfg_ff, opt_ff};
  assign cmd_ready     = ready_ff;
  assign irq           = |(isr_ff & imr_ff);

  // Checks on framing, scheduling and command handling
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_sof;
    disp |=> tx_vld_ff && tx_data_ff == DLE && st_ff == gprs_pkg::TX_ID;
  endproperty
  a_sof: assert property (p_sof) else $error("frame start missing");
  property p_id;
    disp ##1 (slot [*1]) |=> tx_data_ff == rid_ff && st_ff == gprs_pkg::TX_PL;
  endproperty
  a_id: assert property (p_id) else $error("identifier not second");
  property p_stuff;
    pl_ready && pl_valid && pl_data == DLE
      |=> tx_data_ff == DLE ##0 (st_ff == gprs_pkg::TX_STUFF) [*1];
  endproperty
  a_stuff: assert property (p_stuff) else $error("control byte not doubled");
  property p_ready;
    $rose(ready_ff) |-> $past(st_ff) == gprs_pkg::TX_ETX && $past(cur_ff) == gprs_pkg::P_DIFF;
  endproperty
  a_ready: assert property (p_ready) else $error("ready without diff report");
  property p_early;
    rx_end && !ready_ff |=> isr_ff[gprs_pkg::I_BAD] && !pend_ff[gprs_pkg::P_CFG];
  endproperty
  a_early: assert property (p_early) else $error("early command not refused");
  property p_time_req;
    is_time |=> pend_ff[gprs_pkg::P_TIME]
      ##1 (pend_ff[gprs_pkg::P_TIME] || cur_ff == gprs_pkg::P_TIME) [*1];
  endproperty
  a_time_req: assert property (p_time_req) else $error("time request lost");
  property p_noreply;
    is_dc |=> !$rose(pend_ff[gprs_pkg::P_CORR]) && !$rose(pend_ff[gprs_pkg::P_CFG]);
  endproperty
  a_noreply: assert property (p_noreply) else $error("correction load answered");
  property p_pos;
    tk && opt_ff[gprs_pkg::O_XYZ] |=> pend_ff[gprs_pkg::P_PXYZ];
  endproperty
  a_pos: assert property (p_pos) else $error("position report not scheduled");
  property p_diff;
    h_wrap && !diff_active && !is_corq |=> !$rose(pend_ff[gprs_pkg::P_DIFF]);
  endproperty
  a_diff: assert property (p_diff) else $error("diff report not suppressed");
  property p_time_per;
    $rose(pend_ff[gprs_pkg::P_TIME]) && !$past(is_time) |-> $past(t_wrap);
  endproperty
  a_time_per: assert property (p_time_per) else $error("time report off period");
endmodule

// File: verilog/gprs_pkg.sv
// Constants and types of the packet report scheduler
package gprs_pkg;
  // Framing control bytes
  localparam logic [7:0] DLE = 8'h10;
  localparam logic [7:0] ETX = 8'h03;
  // Command identifiers taken from the host
  localparam logic [7:0] C_TIME = 8'h21;
  localparam logic [7:0] C_CORQ = 8'h65;
  localparam logic [7:0] C_CFG  = 8'hbb;
  localparam logic [7:0] C_OPT  = 8'h35;
  localparam logic [7:0] C_DC1  = 8'h60;
  localparam logic [7:0] C_DC2  = 8'h61;
  // Report identifiers sent to the host
  localparam logic [7:0] ID_VER   = 8'h45;
  localparam logic [7:0] ID_HLTH  = 8'h46;
  localparam logic [7:0] ID_STAT  = 8'h4b;
  localparam logic [7:0] ID_XYZ_S = 8'h42;
  localparam logic [7:0] ID_XYZ_D = 8'h83;
  localparam logic [7:0] ID_LLA_S = 8'h4a;
  localparam logic [7:0] ID_LLA_D = 8'h84;
  localparam logic [7:0] ID_SUPER = 8'h8f;
  localparam logic [7:0] ID_VXYZ  = 8'h43;
  localparam logic [7:0] ID_VENU  = 8'h56;
  localparam logic [7:0] ID_TIME  = 8'h41;
  localparam logic [7:0] ID_DIFF  = 8'h82;
  localparam logic [7:0] ID_CORR  = 8'h85;
  localparam logic [7:0] ID_CFG   = C_CFG;
  localparam logic [7:0] SUB_GR_S = 8'h17;
  localparam logic [7:0] SUB_GR_D = 8'h18;
  localparam logic [7:0] SUB_COMB = 8'h20;
  // Pending slots, lower index sent first
  localparam int         NPEND   = 13;
  localparam logic [3:0] P_VER   = 4'h0;
  localparam logic [3:0] P_HLTH  = 4'h1;
  localparam logic [3:0] P_STAT  = 4'h2;
  localparam logic [3:0] P_PXYZ  = 4'h3;
  localparam logic [3:0] P_PLLA  = 4'h4;
  localparam logic [3:0] P_PGRID = 4'h5;
  localparam logic [3:0] P_PCOMB = 4'h6;
  localparam logic [3:0] P_VXYZ  = 4'h7;
  localparam logic [3:0] P_VENU  = 4'h8;
  localparam logic [3:0] P_TIME  = 4'h9;
  localparam logic [3:0] P_DIFF  = 4'ha;
  localparam logic [3:0] P_CORR  = 4'hb;
  localparam logic [3:0] P_CFG   = 4'hc;
  localparam logic [12:0] PU_SET = 13'h0607;
  // Option bit positions
  localparam int O_XYZ  = 0;
  localparam int O_LLA  = 1;
  localparam int O_DBL  = 4;
  localparam int O_GRID = 5;
  localparam int O_VXYZ = 8;
  localparam int O_VENU = 9;
  // Report periods in seconds (150, 15, 30)
  localparam logic [7:0] SEC_FIX   = 8'h96;
  localparam logic [7:0] SEC_NOFIX = 8'h0f;
  localparam logic [4:0] SEC_SLOW  = 5'h1e;
  // Solution epoch
  localparam int unsigned EPOCH_NS  = 1000000000;
  localparam int unsigned CLK_NS    = 25;
  localparam int unsigned EPOCH_CYC = EPOCH_NS / CLK_NS;
  // Register map and reset values
  localparam logic [7:0]  R_OPT   = 8'h00;
  localparam logic [7:0]  R_CFG   = 8'h04;
  localparam logic [7:0]  R_STAT  = 8'h08;
  localparam logic [7:0]  R_ISR   = 8'h0c;
  localparam logic [7:0]  R_IMR   = 8'h10;
  localparam logic [7:0]  R_CNT   = 8'h14;
  localparam logic [15:0] OPT_RST = 16'h0002;
  localparam logic [15:0] CFG_RST = 16'h0a01;
  localparam int          S_PEND  = 16;
  localparam int          I_CMD   = 0;
  localparam int          I_BAD   = 1;
  localparam int          I_SENT  = 2;
  localparam int          I_RDY   = 3;
  localparam logic [1:0]  RSP_OK  = 2'h0;
  localparam logic [1:0]  RSP_ERR = 2'h2;
  typedef enum logic [2:0] {TX_IDLE, TX_ID, TX_PL, TX_STUFF, TX_EDLE,
                            TX_ETX} gprs_tx_e;
endpackage

// File: bench/gprs_host.sv
// Host side model: takes report bytes and feeds report payload
`timescale 1ns/100ps
module gprs_host (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       stall,
  input  wire logic       pl_ready,
  output      logic       tx_ready,
  output      logic [7:0] pl_data,
  output      logic       pl_last,
  output      logic       pl_valid
);
  logic idx_ff;
  // Byte sink, prompt or slow as the bench asks
  always_ff @(posedge clock) begin
    tx_ready <= ~stall;
  end
  // Two payload bytes, the first equal to the control byte
  assign pl_valid = ~rst;
  assign pl_data  = idx_ff ? 8'h5a : gprs_pkg::DLE;
  assign pl_last  = idx_ff;
  always_ff @(posedge clock) begin
    if (rst || (pl_ready && pl_last)) idx_ff <= 1'b0;
    else if (pl_ready) idx_ff <= 1'b1;
  end
endmodule

// File: bench/gps_packet_report_scheduler_tb.sv
// Self-checking bench of the packet report scheduler
`timescale 1ns/100ps
module gps_packet_report_scheduler_tb;
  logic        clock, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, rx_valid, fix_valid, diff_active, stall, tx_ready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        tx_valid, pl_last, pl_valid, pl_ready, nv_wr, cmd_ready, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, rx_data, tx_data, pl_data, report_id, report_sub;
  logic [31:0] s_axi_wdata, s_axi_rdata, nv_rd_word, nv_wr_word, seed;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  logic [7:0]  frm[7] = '{8'h10, 8'h00, 8'h10, 8'h10, 8'h5a, 8'h10, 8'h03};
  int          fails = 0, n_compared = 0, cyc = 0, st = 0, n_nv = 0, t;
  gprs_sched #(.EPOCH_CYCLES(200)) i_gprs_sched (.*);
  gprs_host i_gprs_host (.*);
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk("bresp", s_axi_bresp, gprs_pkg::RSP_OK);
  endtask
  // Bus read, masked data and response compared
  task automatic rdreg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                       input logic [1:0] er);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    chk("rdata", s_axi_rdata & m, e);
    chk("rresp", s_axi_rresp, er);
  endtask
  // One framed command on the receive link
  task automatic send(input logic [7:0] id, input logic [7:0] b0, input int n);
    logic [7:0] f[$];
    f = '{8'h10, id};
    if (n > 0) f.push_back(b0);
    if (n > 1) f.push_back(8'h14);
    f.push_back(8'h10);
    f.push_back(8'h03);
    foreach (f[i]) begin
      rx_valid <= 1'b1;
      rx_data  <= f[i];
      @(posedge clock);
    end
    rx_valid <= 1'b0;
    @(posedge clock);
  endtask
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // Random stalls of the byte sink
  always @(posedge clock) begin
    seed  <= rst ? 32'h1c07 : xs(seed);
    stall <= seed[0];
  end
  // Frame watcher and hang limit
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (nv_wr) n_nv <= n_nv + 1;
    if (tx_valid && tx_ready) begin
      if (st == 1) begin
        e = exp_q.size() ? exp_q.pop_front() : 16'hxxxx;
        chk("report id", tx_data, e[7:0]);
        chk("report tag", report_id, e[7:0]);
        chk("report sub", report_sub, e[15:8]);
      end else begin
        chk("frame byte", tx_data, frm[st]);
      end
      st <= (st == 6) ? 0 : st + 1;
    end
    if (cyc == 22000) begin
      fails++;
      test_done();
    end
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {rx_valid, fix_valid, s_axi_awaddr, s_axi_araddr, rx_data} = '0;
    {s_axi_wdata, rst, diff_active, s_axi_wstrb} = {32'h0, 6'h3f};
    nv_rd_word = 32'h0a010302;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    exp_q = '{8'h45, 8'h46, 8'h4b, 8'h4a, 8'h43, 8'h56, 8'h41, 8'h82};
    send(gprs_pkg::C_TIME, 8'h00, 0);
    for (t = 0; t < 3000 && cmd_ready !== 1'b1; t++) @(posedge clock);
    chk("frames left", exp_q.size(), 0);
    rdreg(gprs_pkg::R_ISR, 32'h2, 32'h2, gprs_pkg::RSP_OK);
    rdreg(gprs_pkg::R_OPT, 32'h0302, 32'hffff, gprs_pkg::RSP_OK);
    wr(gprs_pkg::R_ISR, 32'hf, 4'hf);
    wr(gprs_pkg::R_IMR, 32'h1, 4'hf);
    chk("irq", irq, 1'b0);
    exp_q = '{8'h41, 8'h85, 8'hbb};
    for (t = 1; t <= 60; t++) begin
      if (t % 30 == 0) exp_q.push_back(8'h46);
      if (t % 30 == 0) exp_q.push_back(8'h4b);
      exp_q.push_back(8'h42);
      if (t % 15 == 0 && t <= 30) exp_q.push_back(8'h41);
      if (t == 30) exp_q.push_back(8'h82);
    end
    send(gprs_pkg::C_OPT, 8'h01, 2);
    send(gprs_pkg::C_TIME, 8'h00, 0);
    send(gprs_pkg::C_CORQ, 8'h00, 0);
    send(gprs_pkg::C_CFG, 8'h00, 2);
    send(gprs_pkg::C_DC1, 8'h01, 1);
    send(gprs_pkg::C_DC2, 8'h02, 1);
    send(8'h2b, 8'h00, 0);
    @(posedge clock);
    chk("irq", irq, 1'b1);
    chk("nv word", nv_wr_word, 32'h14001401);
    rdreg(gprs_pkg::R_ISR, 32'h2, 32'h2, gprs_pkg::RSP_OK);
    rdreg(gprs_pkg::R_CNT, 32'h2, 32'hffffffff, gprs_pkg::RSP_OK);
    rdreg(gprs_pkg::R_CFG, 32'h1400, 32'hffffffff, gprs_pkg::RSP_OK);
    rdreg(8'h18, 32'h0, 32'hffffffff, gprs_pkg::RSP_ERR);
    wr(gprs_pkg::R_IMR, 32'h0, 4'hf);
    chk("irq", irq, 1'b0);
    // Second half: fix present, differential mode off
    for (t = 0; t < 19000 && exp_q.size() != 0; t++) begin
      if (exp_q.size() <= 32) {diff_active, fix_valid} <= 2'h1;
      @(posedge clock);
    end
    chk("frames left", exp_q.size(), 0);
    wr(gprs_pkg::R_OPT, 32'h31, 4'h1);
    rdreg(gprs_pkg::R_OPT, 32'h1431, 32'hffff, gprs_pkg::RSP_OK);
    exp_q = '{16'h0083, 16'h188f, 16'h208f};
    for (t = 0; t < 700 && exp_q.size() != 0; t++) @(posedge clock);
    chk("frames left", exp_q.size(), 0);
    chk("nv writes", n_nv, 3);
    test_done();
  end
endmodule
